/* hw/lvd_pkg.sv */
// Package of register offsets, field positions and timing constants for the low-voltage detector control.
package lvd_pkg;
	localparam logic [3:0] ADDR_CONTROL     = 4'h0;
	localparam logic [3:0] ADDR_LEVEL       = 4'h1;
	localparam logic [3:0] ADDR_IRQ_FLAGS   = 4'h2;
	localparam logic [3:0] ADDR_IRQ_MASK    = 4'h3;
	localparam logic [3:0] ADDR_ENABLE_STAT = 4'h4;
	localparam int         BIT_BELOW        = 0;
	localparam int         BIT_ACTION       = 1;
	localparam int         BIT_SOURCE       = 2;
	localparam int         BIT_ENABLE       = 7;
	localparam int         BIT_IRQ_FLAG     = 0;
	localparam int         BIT_IRQ_MASK     = 0;
	localparam int         BIT_SETTLED      = 0;
	localparam logic [7:0] CONTROL_RESET    = 8'h00;
	localparam logic [3:0] LEVEL_RESET      = 4'h0;
	localparam int         CLK_MHZ          = 200;
	localparam int         SETTLE_US        = 10;
	localparam int         SETTLE_CYCLES    = SETTLE_US * CLK_MHZ;
endpackage : lvd_pkg

/* hw/level_sync.sv */
// Two-stage synchroniser for an asynchronous level.
`timescale 1ns/1ps
module level_sync (
	input  wire logic i_mclk,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_sync
);
	logic stage1;

	// The first stage feeds only the second, so metastability never reaches logic.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : level_sync

/* hw/low_voltage_detect_interrupt_ctrl.sv */
// Register file and event logic of the low-voltage detector in interrupt mode.
`timescale 1ns/1ps
module low_voltage_detect_interrupt_ctrl
#(
	parameter int SETTLE_COUNT = lvd_pkg::SETTLE_CYCLES
) (
	input  wire logic       i_mclk,
	input  wire logic       i_nrst,
	input  wire logic [3:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic       i_supply_below,
	input  wire logic       i_external_below,
	output logic [7:0]      o_rdata,
	output logic            o_detect_irq,
	output logic            o_detector_enable,
	output logic            o_detect_source_select,
	output logic [3:0]      o_detect_level_code,
	output logic            o_detect_action_select
);
	import lvd_pkg::*;

	// The settle counter is sixteen bits wide, and a zero count would report settled at once.
	if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65535) begin : g_settle_check
		$error("SETTLE_COUNT out of range");
	end

	logic       detector_enable;
	logic       detect_source_select;
	logic       detect_action_select;
	logic [3:0] detect_level_code;
	logic       detect_irq_request_flag;
	logic       detect_irq_mask;
	logic       below_level_flag;
	logic       below_prev;
	logic       settled;
	logic [15:0] settle_cnt;
	logic       supply_sync;
	logic       external_sync;

	level_sync u_sync_supply (
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_async (i_supply_below),
		.o_sync  (supply_sync)
	);
	level_sync u_sync_external (
		.i_mclk  (i_mclk),
		.i_nrst  (i_nrst),
		.i_async (i_external_below),
		.o_sync  (external_sync)
	);

	wire wr_control = i_wr && (i_addr == ADDR_CONTROL);
	wire wr_level   = i_wr && (i_addr == ADDR_LEVEL);
	wire wr_flags   = i_wr && (i_addr == ADDR_IRQ_FLAGS);
	wire wr_mask    = i_wr && (i_addr == ADDR_IRQ_MASK);
	// Source select chooses the compared comparator; the level code only steers the supply comparator.
	wire compared_below = detect_source_select ? external_sync : supply_sync;
	wire next_enable    = wr_control ? i_wdata[BIT_ENABLE] : detector_enable;
	// Without enable the result is forced to the not-below state.
	wire next_below     = detector_enable && compared_below;
	// A crossing in either direction while enabled makes a one-cycle event.
	wire level_event    = detector_enable && (below_level_flag != below_prev);
	// Turning the detector off while below still reports the drop once.
	wire off_event      = detector_enable && !next_enable && below_level_flag;
	wire request        = (level_event || off_event) && !detect_action_select;

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			detector_enable      <= 1'b0;
			detect_source_select <= 1'b0;
			detect_action_select <= 1'b0;
			detect_level_code    <= LEVEL_RESET;
		end else begin
			detector_enable <= next_enable;
			if (wr_control) begin
				detect_source_select <= i_wdata[BIT_SOURCE];
				detect_action_select <= i_wdata[BIT_ACTION];
			end
			if (wr_level) begin
				detect_level_code <= i_wdata[3:0];
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			below_level_flag <= 1'b0;
			below_prev       <= 1'b0;
		end else begin
			below_level_flag <= next_below;
			// Forgetting the old level while off makes switching back on while below count as a crossing.
			below_prev       <= detector_enable ? below_level_flag : 1'b0;
		end
	end

	// A hardware set wins over a software clear in the same cycle.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			detect_irq_request_flag <= 1'b0;
		end else if (request) begin
			detect_irq_request_flag <= 1'b1;
		end else if (wr_flags) begin
			detect_irq_request_flag <= i_wdata[BIT_IRQ_FLAG];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			detect_irq_mask <= 1'b1;
		end else if (wr_mask) begin
			detect_irq_mask <= i_wdata[BIT_IRQ_MASK];
		end
	end

	// Settle counter only reports status; software still owns the wait.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst || !detector_enable) begin
			settle_cnt <= '0;
			settled    <= 1'b0;
		end else if (settle_cnt < 16'(SETTLE_COUNT)) begin
			settle_cnt <= settle_cnt + 16'h0001;
		end else begin
			settled <= 1'b1;
		end
	end

	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		case (i_addr)
			ADDR_CONTROL: begin
				next_rdata[BIT_ENABLE] = detector_enable;
				next_rdata[BIT_SOURCE] = detect_source_select;
				next_rdata[BIT_ACTION] = detect_action_select;
				next_rdata[BIT_BELOW]  = below_level_flag;
			end
			ADDR_LEVEL:       next_rdata = {4'h0, detect_level_code};
			ADDR_IRQ_FLAGS:   next_rdata[BIT_IRQ_FLAG] = detect_irq_request_flag;
			ADDR_IRQ_MASK:    next_rdata[BIT_IRQ_MASK] = detect_irq_mask;
			ADDR_ENABLE_STAT: next_rdata[BIT_SETTLED]  = settled;
			default:          next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rdata                <= 8'h00;
			o_detect_irq           <= 1'b0;
			o_detector_enable      <= 1'b0;
			o_detect_source_select <= 1'b0;
			o_detect_level_code    <= LEVEL_RESET;
			o_detect_action_select <= 1'b0;
		end else begin
			o_rdata                <= i_rd ? next_rdata : 8'h00;
			o_detect_irq           <= detect_irq_request_flag && !detect_irq_mask;
			o_detector_enable      <= detector_enable;
			o_detect_source_select <= detect_source_select;
			o_detect_level_code    <= detect_level_code;
			o_detect_action_select <= detect_action_select;
		end
	end

	mask_after_reset_a: assert property (@(posedge i_mclk) $rose(i_nrst) |-> detect_irq_mask)
		else $error("mask not set after reset");
	off_while_below_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(off_event && !detect_action_select) |=> detect_irq_request_flag)
		else $error("disable while below did not request");
	crossing_sets_flag_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(level_event && !detect_action_select) |=> detect_irq_request_flag)
		else $error("crossing did not set flag");
	disabled_not_below_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		!detector_enable |=> !below_level_flag)
		else $error("below flag set while disabled");
	irq_masked_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		detect_irq_mask |=> !o_detect_irq)
		else $error("irq seen while masked");
	source_path_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(detector_enable && detect_source_select && external_sync) |=> below_level_flag)
		else $error("external source not used");
	set_over_clear_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(request && wr_flags) |=> detect_irq_request_flag)
		else $error("set lost to clear");
	reset_action_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(detect_action_select && !wr_flags && !detect_irq_request_flag) |=> !detect_irq_request_flag)
		else $error("request in reset action mode");

	sequence below_while_on_s;
		detector_enable && below_level_flag && !detect_action_select;
	endsequence
	sequence switch_off_s;
		wr_control && !i_wdata[BIT_ENABLE];
	endsequence
	sequence enabled_cross_s;
		detector_enable ##1 (detector_enable && !detect_action_select && $changed(below_level_flag));
	endsequence

	disable_drop_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(below_while_on_s ##0 switch_off_s) |=> detect_irq_request_flag)
		else $error("switch-off while below gave no request");
	level_change_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		enabled_cross_s |=> detect_irq_request_flag)
		else $error("level change gave no request");
	supply_path_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(detector_enable && !detect_source_select && supply_sync) |=> below_level_flag)
		else $error("supply source not used");
	mask_gates_irq_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
		(!detect_irq_mask && detect_irq_request_flag) |=> o_detect_irq)
		else $error("unmasked request not shown");
endmodule : low_voltage_detect_interrupt_ctrl

/* test/tb_top.sv */
// Self-checking bench of the low-voltage detector control block.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
	import lvd_pkg::*;
	logic       i_mclk           = 1'b0;
	logic       i_nrst           = 1'b0;
	logic       i_wr             = 1'b0;
	logic       i_rd             = 1'b0;
	logic       i_supply_below   = 1'b0;
	logic       i_external_below = 1'b0;
	logic [3:0] i_addr           = 4'h0;
	logic [7:0] i_wdata          = 8'h00;
	logic [7:0] o_rdata;
	logic [7:0] d;
	logic [3:0] o_detect_level_code;
	logic [3:0] r;
	logic       o_detect_irq;
	logic       o_detector_enable;
	logic       o_detect_source_select;
	logic       o_detect_action_select;
	int         miscompares      = 0;
	int         checks_done      = 0;
	int         cycles           = 0;
	localparam int SETTLE_SIM    = 8;
	always #2.5 i_mclk = ~i_mclk;
	// A short settle count keeps the run brief; the status reads below are timed from it.
	low_voltage_detect_interrupt_ctrl #(.SETTLE_COUNT(SETTLE_SIM)) dut (
		.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_supply_below(i_supply_below), .i_external_below(i_external_below), .o_rdata(o_rdata),
		.o_detect_irq(o_detect_irq), .o_detector_enable(o_detector_enable),
		.o_detect_source_select(o_detect_source_select), .o_detect_level_code(o_detect_level_code),
		.o_detect_action_select(o_detect_action_select));
	function automatic logic [7:0] exp_ctrl(input logic [7:0] w, input logic below);
		return {w[7], 4'h0, w[2], w[1], below};
	endfunction : exp_ctrl
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_mclk);
		i_rd <= 1'b1; i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask : rd
	// The comparator lines need two sync stages plus the flag stage before anything shows.
	task automatic pin(input logic s, input logic e);
		@(posedge i_mclk);
		i_supply_below <= s; i_external_below <= e;
		repeat (8) @(posedge i_mclk);
	endtask : pin
	task automatic wait_irq(input logic e);
		for (int k = 0; k < 10 && o_detect_irq !== e; k++) @(posedge i_mclk);
		#1 `CHK(o_detect_irq, e)
	endtask : wait_irq
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'ha8c2df82));
		repeat (12) @(posedge i_mclk);
		i_nrst <= 1'b1;
		rd(ADDR_CONTROL, d); `CHK(d, CONTROL_RESET)
		rd(ADDR_IRQ_MASK, d); `CHK(d[BIT_IRQ_MASK], 1'b1)
		wr(4'hf, 8'hff); rd(4'hf, d); `CHK(d, 8'h00)
		$display("test reset done");
		repeat (4) begin
			r = 4'($urandom);
			wr(ADDR_LEVEL, {4'h0, r}); rd(ADDR_LEVEL, d); `CHK(d, {4'h0, r})
			`CHK(o_detect_level_code, r)
		end
		$display("test level done");
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CONTROL, 8'h84); rd(ADDR_CONTROL, d); `CHK(d, exp_ctrl(8'h84, 1'b0))
		`CHK({o_detector_enable, o_detect_source_select, o_detect_action_select}, 3'b110)
		rd(ADDR_ENABLE_STAT, d); `CHK(d[BIT_SETTLED], 1'b0)
		repeat (SETTLE_SIM) @(posedge i_mclk);
		rd(ADDR_ENABLE_STAT, d); `CHK(d[BIT_SETTLED], 1'b1)
		pin(1'b1, 1'b0); rd(ADDR_IRQ_FLAGS, d); `CHK(d[BIT_IRQ_FLAG], 1'b0)
		pin(1'b1, 1'b1); rd(ADDR_CONTROL, d); `CHK(d, exp_ctrl(8'h84, 1'b1))
		rd(ADDR_IRQ_FLAGS, d); `CHK(d[BIT_IRQ_FLAG], 1'b1)
		`CHK(o_detect_irq, 1'b0)
		wr(ADDR_IRQ_MASK, 8'h00); wait_irq(1'b1);
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		pin(1'b0, 1'b0); wait_irq(1'b1);
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		$display("test crossing done");
		wr(ADDR_CONTROL, 8'h86); pin(1'b0, 1'b1); rd(ADDR_IRQ_FLAGS, d); `CHK(d[BIT_IRQ_FLAG], 1'b0)
		pin(1'b0, 1'b0); wr(ADDR_CONTROL, 8'h84); wr(ADDR_IRQ_FLAGS, 8'h00);
		pin(1'b0, 1'b1); wait_irq(1'b1);
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		wr(ADDR_CONTROL, 8'h00); wait_irq(1'b1);
		`CHK(o_detector_enable, 1'b0)
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		wr(ADDR_CONTROL, 8'h84); wait_irq(1'b1);
		// The pin moves so that its request reaches the flag on the same edge as a software clear.
		@(posedge i_mclk);
		i_external_below <= 1'b0;
		repeat (2) @(posedge i_mclk);
		wr(ADDR_IRQ_FLAGS, 8'h00); rd(ADDR_IRQ_FLAGS, d); `CHK(d[BIT_IRQ_FLAG], 1'b1)
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		$display("test enable events done");
		wr(ADDR_CONTROL, 8'h00); wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_CONTROL, 8'h80); pin(1'b1, 1'b0); rd(ADDR_CONTROL, d); `CHK(d, exp_ctrl(8'h80, 1'b1))
		wr(ADDR_IRQ_FLAGS, 8'h00); wr(ADDR_IRQ_MASK, 8'h00); wr(ADDR_CONTROL, 8'h80); wait_irq(1'b0);
		pin(1'b0, 1'b0); wait_irq(1'b1);
		repeat (2) begin
			pin(1'b1, 1'b0);
			pin(1'b0, 1'b0);
		end
		rd(ADDR_CONTROL, d); `CHK(d, exp_ctrl(8'h80, 1'b0))
		wr(ADDR_IRQ_FLAGS, 8'h00); wait_irq(1'b0);
		$display("test supply done");
		@(posedge i_mclk);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (4) @(posedge i_mclk);
		rd(ADDR_IRQ_MASK, d); `CHK(d[BIT_IRQ_MASK], 1'b1)
		rd(ADDR_CONTROL, d); `CHK(d, CONTROL_RESET)
		`CHK(o_detect_irq, 1'b0)
		$display("test mid-run reset done");
		summarize();
	end
endmodule : tb_top
